/* design/mrsts_pkg.sv */
// Purpose: Shared constants for the receive association and transmit
//          statistics register bank.
// Assumes: APB with 16 address bits and 32-bit data.
// Notes:   Offsets are byte addresses.
package mrsts_pkg;
    // ==========================================================
    // Sizes
    localparam int NUM_CTX = 8;
    localparam int KEY_WORDS = 4;
    localparam int ADDR_W = 16;
    localparam int KEY_AW = 5;
    // ==========================================================
    // Register offsets
    localparam logic [15:0] OFS_TX_UNTAGGED = 16'h4300;
    localparam logic [15:0] OFS_TX_ENCRYPTED = 16'h4304;
    localparam logic [15:0] OFS_TX_SEC_CTRL = 16'h4390;
    localparam logic [15:0] OFS_SEC_CAP = 16'h4394;
    localparam logic [15:0] OFS_RX_CTRL = 16'hb310;
    localparam logic [15:0] OFS_RX_PN = 16'hb330;
    localparam logic [15:0] OFS_RX_KEY = 16'hb350;
    localparam logic [15:0] SPAN_CTX = 16'h0020;
    localparam logic [15:0] SPAN_KEY = 16'h0080;
    // ==========================================================
    // Field positions
    localparam int AN_LSB = 0;
    localparam int VALID_BIT = 2;
    localparam int FRX_BIT = 3;
    localparam int RETIRED_BIT = 4;
    localparam int TXEN_LSB = 0;
    localparam int STRICT_BIT = 2;
    localparam int HSEL_LSB = 4;
    // ==========================================================
    // Field values and reset values
    localparam logic [1:0] TXEN_MODE_A = 2'h1;
    localparam logic [1:0] TXEN_MODE_B = 2'h2;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [31:0] PN_STEP = 32'h0000_0001;
endpackage

/* design/mrsts_key_mem.sv */
// Purpose: Write-only key store, read only by the cipher datapath.
// Assumes: One write and one read port on the same clock.
// Notes:   Read data come out of a register one cycle after the address.
`timescale 1ns/1ps
`default_nettype none
module mrsts_key_mem #(
    parameter int WIDTH = 32,
    parameter int AW = 5
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    // The register is reset so that the datapath sees zero, not junk, while reset is held.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_data <= '0;
        end
        else
        begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule // mrsts_key_mem
`default_nettype wire

/* design/mrsts_bank.sv */
// Purpose: Receive association contexts and transmit statistics bank.
// Assumes: Frame events come from logic on ref_clk, one pulse per frame.
// Notes:   APB slave with no wait states; unmapped addresses get pslverr.
//
// Behaviour
// - Eight receive association contexts, each with control, number and key.
// - Contexts 2c and 2c+1 belong to receive channel c.
// - Bits 1:0 match the association number of an incoming frame.
// - Bit 3 clears on valid rising, sets when a frame is accepted.
// - Frame received on one context retires the partner context.
// - Bit 4 marks the context invalid; clears when valid rises, unless a frame on the partner context is accepted in that cycle.
// - Replay window zero: one new frame retires the old context.
// - Frame accepted only if its number is at least the stored one.
// - After each accepted frame the stored number becomes frame number plus one.
// - Packet number register is stored and read back unchanged.
// - Key is four words, word 0 lowest bits, word 3 highest.
// - Key words are write-only; reads return zero.
// - A key hash is readable in the capability register.
// - Statistics counters are 32 bits; software extends to 64.
// - Each statistics counter clears when read.
// - Untagged count: secure flag clear, enable field 01b or 10b.
// - Strict mode is stored and driven out on tx_strict_mode; the untagged count ignores it.
// - Encrypted count: controlled port frame with encryption bit set.
`timescale 1ns/1ps
`default_nettype none
module mrsts_bank (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [mrsts_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_frame_valid,
    input wire logic [1:0] rx_frame_channel,
    input wire logic [1:0] rx_frame_an,
    input wire logic [31:0] rx_frame_pn,
    output logic rx_frame_accept,
    output logic rx_frame_reject,
    output logic [2:0] rx_frame_context,
    output logic [7:0] rx_association_usable,
    input wire logic [mrsts_pkg::KEY_AW-1:0] key_rd_addr,
    output logic [31:0] key_rd_data,
    input wire logic tx_frame_done,
    input wire logic descriptor_secure_flag,
    input wire logic tx_controlled_port,
    input wire logic tx_encrypt_bit,
    output logic [1:0] tx_security_enable_field,
    output logic tx_strict_mode
);
    import mrsts_pkg::*;

    typedef struct packed {
        logic [7:0][1:0] an;
        logic [7:0] valid;
        logic [7:0] frx;
        logic [7:0] retired;
        logic [7:0][31:0] pn;
        logic [31:0][7:0] fold;
        logic [31:0] ut_cnt;
        logic [31:0] enc_cnt;
        logic [31:0] prdata;
        logic [1:0] tx_en;
        logic strict;
        logic [2:0] hash_sel;
    } mrsts_state_t;
    mrsts_state_t st;
    mrsts_state_t next_st;
    logic rst_meta_n;
    logic rst_n;

    // ==========================================================
    // Reset release
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_meta_n <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta_n <= 1'b1;
            rst_n <= rst_meta_n;
        end
    end

    // ==========================================================
    // Address decode
    logic setup_rd;
    logic acc;
    logic [15:0] off_ctrl;
    logic [15:0] off_pn;
    logic [15:0] off_key;
    logic hit_ctrl;
    logic hit_pn;
    logic hit_key;
    logic hit_ut;
    logic hit_enc;
    logic hit_txc;
    logic hit_cap;
    logic mapped;
    logic [2:0] ctx_ctrl;
    logic [2:0] ctx_pn;
    logic [KEY_AW-1:0] key_idx;
    assign setup_rd = psel && !penable && !pwrite;
    assign acc = psel && penable;
    assign off_ctrl = paddr - OFS_RX_CTRL;
    assign off_pn = paddr - OFS_RX_PN;
    assign off_key = paddr - OFS_RX_KEY;
    assign hit_ctrl = paddr >= OFS_RX_CTRL && off_ctrl < SPAN_CTX;
    assign hit_pn = paddr >= OFS_RX_PN && off_pn < SPAN_CTX;
    assign hit_key = paddr >= OFS_RX_KEY && off_key < SPAN_KEY;
    assign hit_ut = paddr == OFS_TX_UNTAGGED;
    assign hit_enc = paddr == OFS_TX_ENCRYPTED;
    assign hit_txc = paddr == OFS_TX_SEC_CTRL;
    assign hit_cap = paddr == OFS_SEC_CAP;
    assign mapped = (paddr[1:0] == 2'h0) && (hit_ctrl || hit_pn || hit_key
        || hit_ut || hit_enc || hit_txc || hit_cap);
    assign ctx_ctrl = off_ctrl[4:2];
    assign ctx_pn = off_pn[4:2];
    assign key_idx = off_key[6:2];

    assign pready = 1'b1;
    assign pslverr = acc && !mapped;

    // ==========================================================
    // Receive context match
    logic [2:0] ctx_even;
    logic [2:0] ctx_sel;
    logic hit_even;
    logic hit_odd;
    logic ctx_found;
    logic pn_ok;
    assign ctx_even = {rx_frame_channel, 1'b0};
    assign hit_even = st.valid[ctx_even] && !st.retired[ctx_even]
        && st.an[ctx_even] == rx_frame_an;
    assign hit_odd = st.valid[ctx_even | 3'h1]
        && !st.retired[ctx_even | 3'h1]
        && st.an[ctx_even | 3'h1] == rx_frame_an;
    assign ctx_sel = hit_even ? ctx_even : (ctx_even | 3'h1);
    assign ctx_found = hit_even || hit_odd;
    assign pn_ok = rx_frame_pn >= st.pn[ctx_sel];
    assign rx_frame_accept = rx_frame_valid && ctx_found && pn_ok;
    assign rx_frame_reject = rx_frame_valid && !rx_frame_accept;
    assign rx_frame_context = ctx_sel;
    assign rx_association_usable = st.valid & ~st.retired;
    assign tx_security_enable_field = st.tx_en;
    assign tx_strict_mode = st.strict;

    // ==========================================================
    // Transmit events
    logic ut_inc;
    logic enc_inc;
    assign ut_inc = tx_frame_done && !descriptor_secure_flag
        && (st.tx_en == TXEN_MODE_A || st.tx_en == TXEN_MODE_B);
    assign enc_inc = tx_frame_done && tx_controlled_port && tx_encrypt_bit;

    // ==========================================================
    // Next state
    always_comb
    begin
        logic [7:0] hash;
        logic [31:0] rd;
        hash = 8'h00;
        rd = RST_WORD;
        next_st = st;
        for (int w = 0; w < KEY_WORDS; w++)
        begin
            hash = hash ^ st.fold[{st.hash_sel, w[1:0]}];
        end
        // Read data are captured in the setup cycle.
        if (setup_rd)
        begin
            if (hit_ctrl)
            begin
                rd[AN_LSB+:2] = st.an[ctx_ctrl];
                rd[VALID_BIT] = st.valid[ctx_ctrl];
                rd[FRX_BIT] = st.frx[ctx_ctrl];
                rd[RETIRED_BIT] = st.retired[ctx_ctrl];
            end
            else if (hit_pn)
            begin
                rd = st.pn[ctx_pn];
            end
            else if (hit_ut)
            begin
                rd = st.ut_cnt;
            end
            else if (hit_enc)
            begin
                rd = st.enc_cnt;
            end
            else if (hit_txc)
            begin
                rd[TXEN_LSB+:2] = st.tx_en;
                rd[STRICT_BIT] = st.strict;
                rd[HSEL_LSB+:3] = st.hash_sel;
            end
            else if (hit_cap)
            begin
                rd[7:0] = hash;
            end
            // key reads give zero
            // Unaligned or unmapped reads answer zero with the error.
            next_st.prdata = mapped ? rd : RST_WORD;
        end

        next_st.ut_cnt = st.ut_cnt + {31'h0, ut_inc};
        next_st.enc_cnt = st.enc_cnt + {31'h0, enc_inc};
        if (acc && !pwrite && mapped)
        begin
            // clear on read
            // Counts taken between setup and access are kept, not lost.
            if (hit_ut)
            begin
                next_st.ut_cnt = st.ut_cnt - st.prdata + {31'h0, ut_inc};
            end
            if (hit_enc)
            begin
                next_st.enc_cnt = st.enc_cnt - st.prdata + {31'h0, enc_inc};
            end
        end
        if (acc && pwrite && mapped)
        begin
            if (hit_ctrl)
            begin
                next_st.an[ctx_ctrl] = pwdata[AN_LSB+:2];
                next_st.valid[ctx_ctrl] = pwdata[VALID_BIT];
                if (pwdata[VALID_BIT] && !st.valid[ctx_ctrl])
                begin
                    next_st.frx[ctx_ctrl] = 1'b0;
                    next_st.retired[ctx_ctrl] = 1'b0;
                end
            end
            else if (hit_pn)
            begin
                next_st.pn[ctx_pn] = pwdata;
            end
            else if (hit_key)
            begin
                next_st.fold[key_idx] = pwdata[31:24] ^ pwdata[23:16]
                    ^ pwdata[15:8] ^ pwdata[7:0];
            end
            else if (hit_txc)
            begin
                next_st.tx_en = pwdata[TXEN_LSB+:2];
                next_st.strict = pwdata[STRICT_BIT];
                next_st.hash_sel = pwdata[HSEL_LSB+:3];
            end
        end

        // Frame effects come last so that they win over a write.
        if (rx_frame_accept)
        begin
            next_st.frx[ctx_sel] = 1'b1;
            next_st.retired[ctx_sel ^ 3'h1] = 1'b1;
            next_st.pn[ctx_sel] = rx_frame_pn + PN_STEP;
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign prdata = st.prdata;

    // ==========================================================
    // Key storage
    // per-context keys
    mrsts_key_mem #(
        .WIDTH(32),
        .AW(KEY_AW)
    ) u_key_mem (
        .clk(ref_clk),
        .rst_n(rst_n),
        .wr_en(acc && pwrite && mapped && hit_key),
        .wr_addr(key_idx),
        .wr_data(pwdata),
        .rd_addr(key_rd_addr),
        .rd_data(key_rd_data)
    );

    // ==========================================================
    // Checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_key_setup;
        psel && !penable && !pwrite && hit_key && mapped;
    endsequence
    sequence s_ut_read;
        psel && penable && !pwrite && hit_ut && !ut_inc;
    endsequence

    a_accept_sets_frx: assert property (
        rx_frame_accept |=> st.frx[$past(ctx_sel)])
        else $error("frame received flag not set");
    a_partner_retired: assert property (
        rx_frame_accept |=> st.retired[$past(ctx_sel) ^ 3'h1]
            && !rx_association_usable[$past(ctx_sel) ^ 3'h1])
        else $error("partner context not retired");
    a_pn_update: assert property (
        rx_frame_accept |=> st.pn[$past(ctx_sel)] == $past(rx_frame_pn) + 1)
        else $error("packet number not advanced");
    a_replay_check: assert property (
        rx_frame_accept |-> rx_frame_pn >= st.pn[ctx_sel])
        else $error("frame accepted below stored number");
    a_channel_pair: assert property (
        rx_frame_accept |-> ctx_sel[2:1] == rx_frame_channel
            && st.an[ctx_sel] == rx_frame_an)
        else $error("context outside frame channel");
    a_valid_rise: assert property (
        acc && pwrite && mapped && hit_ctrl && pwdata[VALID_BIT]
            && !st.valid[ctx_ctrl] && !rx_frame_valid
            |=> !st.frx[$past(ctx_ctrl)] && !st.retired[$past(ctx_ctrl)])
        else $error("flags not cleared on valid rise");
    a_key_read_zero: assert property (
        s_key_setup ##1 (psel && penable) |-> prdata == 32'h0000_0000)
        else $error("key read returned data");
    a_ut_clear: assert property (
        s_ut_read |=> st.ut_cnt == $past(st.ut_cnt) - $past(st.prdata))
        else $error("counter not cleared on read");
    a_ut_gate: assert property (
        !(acc && hit_ut) && (descriptor_secure_flag || st.tx_en == 2'h0
            || st.tx_en == 2'h3) |=> st.ut_cnt == $past(st.ut_cnt))
        else $error("untagged count moved while gated");
    a_enc_count: assert property (
        enc_inc && !(acc && hit_enc) |=> st.enc_cnt == $past(st.enc_cnt) + 1)
        else $error("encrypted count missed a frame");
endmodule // mrsts_bank
`default_nettype wire

/* verification/mrsts_tb.sv */
// Purpose: Self-checking bench for the association and statistics bank.
// Assumes: APB slave answers in the access cycle; frames are one-cycle pulses.
// Notes:   All inputs but ref_clk are driven by non-blocking assignment at rising edges.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import mrsts_pkg::*;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rx_frame_valid = 1'b0;
    logic [1:0] rx_frame_channel = '0;
    logic [1:0] rx_frame_an = '0;
    logic [31:0] rx_frame_pn = '0;
    logic rx_frame_accept;
    logic rx_frame_reject;
    logic [2:0] rx_frame_context;
    logic [7:0] rx_association_usable;
    logic [KEY_AW-1:0] key_rd_addr = '0;
    logic [31:0] key_rd_data;
    logic tx_frame_done = 1'b0;
    logic descriptor_secure_flag = 1'b0;
    logic tx_controlled_port = 1'b0;
    logic tx_encrypt_bit = 1'b0;
    logic [1:0] tx_security_enable_field;
    logic tx_strict_mode;
    int error_cnt = 0;
    int n_checks = 0;
    logic [31:0] rd;
    logic er;
    logic [31:0] key [4];
    logic [7:0] hash;

    always #2 ref_clk = ~ref_clk;

    mrsts_bank i_mrsts_bank (
        .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_frame_valid(rx_frame_valid),
        .rx_frame_channel(rx_frame_channel), .rx_frame_an(rx_frame_an),
        .rx_frame_pn(rx_frame_pn), .rx_frame_accept(rx_frame_accept),
        .rx_frame_reject(rx_frame_reject),
        .rx_frame_context(rx_frame_context),
        .rx_association_usable(rx_association_usable),
        .key_rd_addr(key_rd_addr), .key_rd_data(key_rd_data),
        .tx_frame_done(tx_frame_done),
        .descriptor_secure_flag(descriptor_secure_flag),
        .tx_controlled_port(tx_controlled_port),
        .tx_encrypt_bit(tx_encrypt_bit),
        .tx_security_enable_field(tx_security_enable_field),
        .tx_strict_mode(tx_strict_mode)
    );

    // ==========================================================
    // Reporting
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // ==========================================================
    // Bus and event drivers
    task automatic apb(input logic w, input logic [15:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++)
        begin
            @(posedge ref_clk);
            if (pready === 1'b1)
                break;
        end
        if (i == 16)
        begin
            error_cnt++;
            $display("FAIL %0t bus transfer got no ready", $time);
            test_done();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [15:0] a, input logic [31:0] exp,
                         input logic exp_err);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
        chk(32'(er), 32'(exp_err));
    endtask

    task automatic frame(input logic [1:0] ch, input logic [1:0] an,
                         input logic [31:0] pn, input logic acc,
                         input logic [2:0] ctx);
        @(posedge ref_clk);
        rx_frame_valid <= 1'b1;
        rx_frame_channel <= ch;
        rx_frame_an <= an;
        rx_frame_pn <= pn;
        #1;
        chk(32'(rx_frame_accept), 32'(acc));
        chk(32'(rx_frame_reject), 32'(!acc));
        if (acc)
            chk(32'(rx_frame_context), 32'(ctx));
        @(posedge ref_clk);
        rx_frame_valid <= 1'b0;
    endtask

    task automatic tx(input logic sec, input logic ctl, input logic enc);
        @(posedge ref_clk);
        tx_frame_done <= 1'b1;
        descriptor_secure_flag <= sec;
        tx_controlled_port <= ctl;
        tx_encrypt_bit <= enc;
        @(posedge ref_clk);
        tx_frame_done <= 1'b0;
    endtask

    function automatic logic [15:0] ca(input int n);
        return OFS_RX_CTRL + 16'(4 * n);
    endfunction

    function automatic logic [15:0] pa(input int n);
        return OFS_RX_PN + 16'(4 * n);
    endfunction

    function automatic logic [15:0] ka(input int n, input int m);
        return OFS_RX_KEY + 16'(16 * n + 4 * m);
    endfunction

    function automatic logic [7:0] fold(input logic [31:0] w);
        return w[7:0] ^ w[15:8] ^ w[23:16] ^ w[31:24];
    endfunction

    // ==========================================================
    // Main sequence
    initial
    begin
        repeat (8) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        for (int n = 0; n < NUM_CTX; n++)
        begin
            rdchk(ca(n), RST_WORD, 1'b0);
            rdchk(pa(n), RST_WORD, 1'b0);
        end
        rdchk(OFS_TX_UNTAGGED, RST_WORD, 1'b0);
        rdchk(16'h1000, RST_WORD, 1'b1);
        rdchk(16'hb312, RST_WORD, 1'b1);
        $display("test reset values done");

        key = '{32'h0123_4567, 32'h89ab_cdef, 32'h5a5a_0f0f, 32'hdead_0001};
        hash = 8'h00;
        for (int m = 0; m < KEY_WORDS; m++)
        begin
            wr(ka(2, m), key[m]);
            hash = hash ^ fold(key[m]);
        end
        for (int m = 0; m < KEY_WORDS; m++)
        begin
            rdchk(ka(2, m), RST_WORD, 1'b0);
            @(posedge ref_clk);
            key_rd_addr <= KEY_AW'(2 * KEY_WORDS + m);
            @(posedge ref_clk);
            #1;
            chk(key_rd_data, key[m]);
        end
        wr(OFS_TX_SEC_CTRL, 32'h0000_0020);
        rdchk(OFS_SEC_CAP, {24'h00_0000, hash}, 1'b0);
        $display("test key store done");

        wr(pa(3), 32'h1234_5678);
        rdchk(pa(3), 32'h1234_5678, 1'b0);
        wr(ca(0), 32'h0000_0005);
        wr(ca(1), 32'h0000_0006);
        wr(pa(0), 32'h0000_0005);
        // Let the last write settle before looking at the flops.
        #1;
        chk(32'(rx_association_usable), 32'h0000_0003);
        frame(2'd0, 2'd1, 32'h0000_0004, 1'b0, 3'd0);
        frame(2'd0, 2'd3, 32'h0000_0009, 1'b0, 3'd0);
        frame(2'd1, 2'd1, 32'h0000_0009, 1'b0, 3'd0);
        frame(2'd0, 2'd1, 32'h0000_0005, 1'b1, 3'd0);
        rdchk(ca(0), 32'h0000_000d, 1'b0);
        rdchk(ca(1), 32'h0000_0016, 1'b0);
        rdchk(pa(0), 32'h0000_0006, 1'b0);
        chk(32'(rx_association_usable), 32'h0000_0001);
        frame(2'd0, 2'd2, 32'h0000_0009, 1'b0, 3'd1);
        frame(2'd0, 2'd1, 32'h0000_0005, 1'b0, 3'd0);
        wr(ca(1), 32'h0000_0000);
        wr(ca(1), 32'hffff_ffe6);
        rdchk(ca(1), 32'h0000_0006, 1'b0);
        frame(2'd0, 2'd2, 32'h0000_0000, 1'b1, 3'd1);
        rdchk(ca(0), 32'h0000_001d, 1'b0);
        rdchk(ca(1), 32'h0000_000e, 1'b0);
        wr(ca(6), 32'h0000_0004);
        frame(2'd2, 2'd0, 32'h0000_0000, 1'b0, 3'd4);
        frame(2'd3, 2'd0, 32'h0000_0000, 1'b1, 3'd6);
        $display("test associations done");

        rdchk(OFS_TX_UNTAGGED, RST_WORD, 1'b0);
        wr(OFS_TX_SEC_CTRL, 32'h0000_0000);
        tx(1'b0, 1'b0, 1'b0);
        wr(OFS_TX_SEC_CTRL, 32'h0000_0001);
        tx(1'b0, 1'b0, 1'b0);
        tx(1'b1, 1'b1, 1'b0);
        wr(OFS_TX_SEC_CTRL, 32'h0000_0006);
        // The control write lands at the access edge; wait for it.
        #1;
        chk(32'(tx_strict_mode), 32'h0000_0001);
        chk(32'(tx_security_enable_field), 32'h0000_0002);
        tx(1'b0, 1'b0, 1'b0);
        wr(OFS_TX_SEC_CTRL, 32'h0000_0003);
        tx(1'b0, 1'b0, 1'b0);
        rdchk(OFS_TX_UNTAGGED, 32'h0000_0002, 1'b0);
        rdchk(OFS_TX_UNTAGGED, RST_WORD, 1'b0);
        tx(1'b1, 1'b1, 1'b1);
        tx(1'b1, 1'b0, 1'b1);
        tx(1'b1, 1'b1, 1'b1);
        rdchk(OFS_TX_ENCRYPTED, 32'h0000_0002, 1'b0);
        rdchk(OFS_TX_ENCRYPTED, RST_WORD, 1'b0);
        $display("test statistics done");
        test_done();
    end
endmodule // tb
`default_nettype wire
